// [core/xmb_bus_if.v]
// external memory bus engine: strobes, muxed address/data, space select, vector fetch
`timescale 1ns/1ps
`include "xmb_defines.vh"
module xmb_bus_if
(
   // clock and reset
   input  wire        I_CLOCK,
   input  wire        I_RESET,
   // core request side
   input  wire        I_REQ,
   input  wire        I_REQ_WRITE,
   input  wire [15:0] I_REQ_ADDR,
   input  wire [7:0]  I_REQ_WDATA,
   input  wire [1:0]  I_REQ_KIND,
   input  wire        I_REQ_MOVE_SPACE,
   input  wire        I_SEL_DATA_SPACE_OP,
   input  wire        I_SEL_PROG_SPACE_OP,
   input  wire        I_FLOAT_BUS,
   input  wire [2:0]  I_PROG_WAIT,
   input  wire [2:0]  I_DATA_WAIT,
   output wire        O_REQ_READY,
   output reg         O_RESP_VALID,
   output reg  [7:0]  O_RESP_RDATA,
   output reg         O_VEC_VALID,
   output reg  [15:0] O_START_ADDR,
   // internal rom port
   output reg  [15:0] O_ROM_ADDR,
   input  wire [7:0]  I_ROM_DATA,
   // external bus pins
   output reg         O_ADDR_LATCH_STROBE_N,
   output reg         O_DATA_XFER_STROBE_N,
   output reg         O_READ_NOT_WRITE,
   output reg         O_SPACE_PROG,
   output wire        O_CTRL_OE,
   input  wire [7:0]  I_MUXED_AD,
   output reg  [7:0]  O_MUXED_AD,
   output wire [7:0]  O_MUXED_AD_OE,
   output reg  [7:0]  O_HIGH_ADDR,
   output wire [7:0]  O_HIGH_ADDR_OE,
   input  wire        I_EXT_WAIT,
   input  wire        I_BUS_HOLD_REQUEST_N,
   output reg         O_BUS_HOLD_GRANT_N
);
   localparam S_IDLE  = 3'h0;
   localparam S_ADDR  = 3'h1;
   localparam S_LATCH = 3'h2;
   localparam S_DATA  = 3'h3;
   localparam S_END   = 3'h4;
   localparam S_INT   = 3'h5;
   localparam S_HOLD  = 3'h6;

   wire        wait_s;
   wire        hold_req_n_s;
   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg         space_sel_r;
   reg         cyc_space_r;
   reg         cyc_write_r;
   reg  [15:0] cyc_addr_r;
   reg  [7:0]  cyc_wdata_r;
   reg         ad_drive_r;
   reg         drive_r;
   reg  [2:0]  wait_cnt_r;
   reg  [1:0]  vec_step_r;
   reg  [7:0]  vec_hi_r;
   reg         vec_active_r;
   reg         req_space;

   xmb_sync2 #(.RESET_VAL(1'b0)) u_wait_sync
   (
      .i_clk (I_CLOCK),
      .i_rst (I_RESET),
      .i_d   (I_EXT_WAIT),
      .o_q   (wait_s)
   );
   xmb_sync2 #(.RESET_VAL(1'b1)) u_hold_sync
   (
      .i_clk (I_CLOCK),
      .i_rst (I_RESET),
      .i_d   (I_BUS_HOLD_REQUEST_N),
      .o_q   (hold_req_n_s)
   );

   // internal rom only in program space
   function is_internal;
      input [15:0] addr;
      input        space;
      begin
         is_internal = (space == `XMB_SPACE_PROG) && (addr <= `XMB_ROM_LAST);
      end
   endfunction

   // space of a new cycle: stack forces data, moves follow opcode
   always @*
   begin
      case (I_REQ_KIND)
         `XMB_KIND_STACK: req_space = `XMB_SPACE_DATA;
         `XMB_KIND_MOVE:  req_space = I_REQ_MOVE_SPACE;
         default:         req_space = space_sel_r;
      endcase
   end

   wire start_ok = (state_r == S_IDLE) && !vec_active_r && hold_req_n_s && !I_FLOAT_BUS;
   assign O_REQ_READY = start_ok;
   wire vec_start = (state_r == S_IDLE) && vec_active_r && hold_req_n_s && !I_FLOAT_BUS;
   wire new_cyc = (start_ok && I_REQ) || vec_start;
   wire new_space = vec_active_r ? `XMB_SPACE_PROG : req_space;
   wire [15:0] new_addr = vec_active_r ? (vec_step_r[0] ? `XMB_VEC_LO_ADDR : `XMB_VEC_HI_ADDR) : I_REQ_ADDR;
   wire new_write = vec_active_r ? 1'b0 : I_REQ_WRITE;
   wire [2:0] wait_cfg = (cyc_space_r == `XMB_SPACE_PROG) ? I_PROG_WAIT : I_DATA_WAIT;

   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE:
         begin
            if (!hold_req_n_s)
               state_nxt = S_HOLD;
            else if (new_cyc)
               state_nxt = is_internal(new_addr, new_space) ? S_INT : S_ADDR;
         end
         S_ADDR:  state_nxt = S_LATCH;
         S_LATCH: state_nxt = S_DATA;
         S_DATA:
         begin
            // pin wait is seen two clocks late; programmed waits must cover that
            if (wait_cnt_r == 3'h0 && !wait_s)
               state_nxt = S_END;
         end
         S_END:   state_nxt = S_IDLE;
         S_INT:   state_nxt = S_IDLE;
         S_HOLD:
         begin
            if (hold_req_n_s)
               state_nxt = S_IDLE;
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   // pins float together under program control or while bus is granted
   assign O_CTRL_OE      = drive_r;
   assign O_MUXED_AD_OE  = {8{drive_r & ad_drive_r}};
   assign O_HIGH_ADDR_OE = {8{drive_r}};

   always @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         state_r               <= S_IDLE;
         space_sel_r           <= `XMB_SPACE_PROG;
         cyc_space_r           <= `XMB_SPACE_PROG;
         cyc_write_r           <= 1'b0;
         cyc_addr_r            <= 16'h0000;
         cyc_wdata_r           <= 8'h00;
         ad_drive_r            <= 1'b0;
         drive_r               <= 1'b0;
         wait_cnt_r            <= 3'h0;
         vec_step_r            <= 2'h0;
         vec_hi_r              <= 8'h00;
         vec_active_r          <= 1'b1;
         O_RESP_VALID          <= 1'b0;
         O_RESP_RDATA          <= 8'h00;
         O_VEC_VALID           <= 1'b0;
         O_START_ADDR          <= 16'h0000;
         O_ROM_ADDR            <= 16'h0000;
         O_ADDR_LATCH_STROBE_N <= 1'b1;
         O_DATA_XFER_STROBE_N  <= 1'b1;
         O_READ_NOT_WRITE      <= 1'b1;
         O_SPACE_PROG          <= `XMB_SPACE_PROG;
         O_MUXED_AD            <= 8'h00;
         O_HIGH_ADDR           <= 8'h00;
         O_BUS_HOLD_GRANT_N    <= 1'b1;
      end
      else
      begin
         state_r      <= state_nxt;
         O_RESP_VALID <= 1'b0;
         O_VEC_VALID  <= 1'b0;
         if (I_SEL_DATA_SPACE_OP)
            space_sel_r <= `XMB_SPACE_DATA;
         else if (I_SEL_PROG_SPACE_OP)
            space_sel_r <= `XMB_SPACE_PROG;
         // float only between cycles so no cycle is cut short
         if (state_r == S_IDLE || state_r == S_HOLD)
            drive_r <= !I_FLOAT_BUS && (state_nxt != S_HOLD);
         O_BUS_HOLD_GRANT_N <= !(state_nxt == S_HOLD);
         case (state_r)
            S_IDLE:
            begin
               if (new_cyc && hold_req_n_s)
               begin
                  cyc_addr_r  <= new_addr;
                  cyc_space_r <= new_space;
                  cyc_write_r <= new_write;
                  cyc_wdata_r <= I_REQ_WDATA;
                  O_ROM_ADDR  <= new_addr;
                  if (!is_internal(new_addr, new_space))
                  begin
                     // address, direction and space set up ahead of strobe
                     O_MUXED_AD       <= new_addr[7:0];
                     O_HIGH_ADDR      <= new_addr[15:8];
                     O_SPACE_PROG     <= new_space;
                     O_READ_NOT_WRITE <= !new_write;
                     ad_drive_r       <= 1'b1;
                  end
               end
            end
            S_ADDR:
               O_ADDR_LATCH_STROBE_N <= 1'b0;
            S_LATCH:
            begin
               O_ADDR_LATCH_STROBE_N <= 1'b1;
               O_DATA_XFER_STROBE_N  <= 1'b0;
               wait_cnt_r            <= wait_cfg;
               if (cyc_write_r)
                  O_MUXED_AD <= cyc_wdata_r;
               else
                  ad_drive_r <= 1'b0;
            end
            S_DATA:
            begin
               if (wait_cnt_r != 3'h0)
                  wait_cnt_r <= wait_cnt_r - 3'h1;
               if (state_nxt == S_END)
               begin
                  O_DATA_XFER_STROBE_N <= 1'b1;
                  O_RESP_RDATA         <= I_MUXED_AD;
               end
            end
            S_END:
            begin
               O_READ_NOT_WRITE <= 1'b1;
               ad_drive_r       <= 1'b0;
            end
            default:
            begin
            end
         endcase
         // finish: S_END for external, S_INT for rom (data strobe untouched)
         if (state_r == S_END || state_r == S_INT)
         begin
            if (vec_active_r)
            begin
               if (vec_step_r[0])
               begin
                  O_START_ADDR <= {vec_hi_r, (state_r == S_INT) ? I_ROM_DATA : O_RESP_RDATA};
                  O_VEC_VALID  <= 1'b1;
                  vec_active_r <= 1'b0;
               end
               else
                  vec_hi_r <= (state_r == S_INT) ? I_ROM_DATA : O_RESP_RDATA;
               vec_step_r <= vec_step_r + 2'h1;
            end
            else
            begin
               O_RESP_VALID <= 1'b1;
               if (state_r == S_INT)
                  O_RESP_RDATA <= I_ROM_DATA;
            end
         end
      end
   end
endmodule // xmb_bus_if

// [core/xmb_defines.vh]
// constants for the external memory bus interface
`ifndef XMB_DEFINES_VH
`define XMB_DEFINES_VH
`define XMB_ROM_LAST      16'h1fff
`define XMB_VEC_HI_ADDR   16'h0000
`define XMB_VEC_LO_ADDR   16'h0001
`define XMB_WAIT_W        3
`define XMB_SPACE_PROG    1'b1
`define XMB_SPACE_DATA    1'b0
`define XMB_KIND_NORMAL   2'h0
`define XMB_KIND_STACK    2'h1
`define XMB_KIND_MOVE     2'h2
`endif

// [core/xmb_sync2.v]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module xmb_sync2
#(
   parameter RESET_VAL = 1'b1
)
(
   input  wire i_clk,
   input  wire i_rst,
   input  wire i_d,
   output wire o_q
);
   reg stage1_r;
   reg stage2_r;
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         stage1_r <= RESET_VAL;
         stage2_r <= RESET_VAL;
      end
      else
      begin
         stage1_r <= i_d;
         stage2_r <= stage1_r;
      end
   end
   assign o_q = stage2_r;
endmodule // xmb_sync2

// [dv/xmb_bus_if_assertions.sv]
// concurrent checks on the external memory bus pins
`timescale 1ns/1ps
module xmb_bus_if_chk
(
   // clock and reset
   input wire       I_CLOCK,
   input wire       I_RESET,
   // watched ports
   input wire       I_FLOAT_BUS,
   input wire       O_REQ_READY,
   input wire       O_RESP_VALID,
   input wire       O_ADDR_LATCH_STROBE_N,
   input wire       O_DATA_XFER_STROBE_N,
   input wire       O_READ_NOT_WRITE,
   input wire       O_SPACE_PROG,
   input wire       O_CTRL_OE,
   input wire [7:0] O_MUXED_AD_OE,
   input wire [7:0] O_HIGH_ADDR,
   input wire [7:0] O_HIGH_ADDR_OE,
   input wire       O_BUS_HOLD_GRANT_N
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RESET);
   wire as_n = O_ADDR_LATCH_STROBE_N;
   wire ds_n = O_DATA_XFER_STROBE_N;
   wire rnw  = O_READ_NOT_WRITE;
   a_as_one_cycle: assert property ($fell(as_n) |=> $rose(as_n))
      else $error("address strobe not a one cycle pulse");
   a_addr_settled: assert property ($rose(as_n) |-> $stable(O_HIGH_ADDR) && $stable(rnw) && $stable(O_SPACE_PROG))
      else $error("address phase moved at strobe rise");
   a_ds_after_as: assert property ($rose(as_n) |-> $fell(ds_n))
      else $error("data strobe did not follow address strobe");
   a_float_all: assert property (!O_CTRL_OE |-> O_MUXED_AD_OE == 8'h00 && O_HIGH_ADDR_OE == 8'h00)
      else $error("ports driven while strobes floated");
   a_float_blocks: assert property (I_FLOAT_BUS [*2] |-> !O_REQ_READY)
      else $error("ready while bus floated");
   a_wr_data_out: assert property ($fell(ds_n) && !rnw |-> O_MUXED_AD_OE == 8'hff)
      else $error("write data not driven at strobe fall");
   a_rd_released: assert property ($fell(ds_n) && rnw |-> O_MUXED_AD_OE == 8'h00)
      else $error("low port not released for read");
   a_resp_after_ds: assert property ($rose(ds_n) |=> O_RESP_VALID)
      else $error("no response after data strobe");
   a_hold_floats: assert property (!O_BUS_HOLD_GRANT_N |-> !O_CTRL_OE)
      else $error("bus driven while granted away");
   a_float_on_request: assert property ($fell(O_CTRL_OE) |-> $past(I_FLOAT_BUS) || !O_BUS_HOLD_GRANT_N)
      else $error("bus floated without a request");
endmodule // xmb_bus_if_chk
bind xmb_bus_if xmb_bus_if_chk xmb_bus_if_chk_i (.*);

// [dv/xmb_ext_mem.sv]
// external program/data memory with address latch and wait output
`timescale 1ns/1ps
module xmb_ext_mem
(
   // bus pins
   input  wire       i_clk,
   input  wire       i_as_n,
   input  wire       i_ds_n,
   input  wire       i_rnw,
   input  wire       i_space,
   input  wire [7:0] i_ad,
   input  wire       i_slow,
   output wire [7:0] o_ad,
   output wire       o_ad_en,
   output wire       o_wait
);
   reg [7:0] mem [0:511];
   reg [8:0] adr_r;
   reg       rnw_r;
   reg [2:0] cnt_r = 3'h0;
   integer   k;
   initial for (k = 0; k < 512; k = k + 1) mem[k] = k[7:0] + 8'h11;
   // space bit splits the two 256-byte maps (only the low address byte is latched)
   // clocked latch: the low port turns to write data on the edge that ends the strobe
   always @(posedge i_clk) if (!i_as_n) {rnw_r, adr_r} <= {i_rnw, i_space, i_ad};
   always @(posedge i_clk) if (!i_ds_n && !rnw_r) mem[adr_r] <= i_ad;
   always @(posedge i_clk) cnt_r <= i_ds_n ? 3'h0 : cnt_r + {2'h0, cnt_r != 3'h7};
   assign o_wait  = i_slow && !i_ds_n && cnt_r < 3'h4;
   assign o_ad_en = !i_ds_n && rnw_r;
   assign o_ad    = mem[adr_r];
endmodule // xmb_ext_mem

// [dv/xmb_bus_if_tb_top.sv]
// self-checking bench for the external memory bus interface
`timescale 1ns/1ps
`define XMB_CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module xmb_bus_if_tb_top;
   typedef struct {bit w; bit [1:0] k; bit ms; bit [15:0] a; bit [7:0] d; bit [7:0] e; int lat; bit [2:0] pw;} xmb_row_t;
   reg clk = 0, rst = 1, req = 0, wr = 0, ms = 0, sdo = 0, spo = 0, flt = 0, slow = 0, hold_n = 1;
   reg [15:0] addr = 16'h0000;
   reg [7:0]  wd = 8'h00, rd;
   reg [1:0]  kind = 2'h0;
   reg [2:0]  pw = 3'h0, dw = 3'h0;
   wire [15:0] rom_a, start;
   wire [7:0]  rdata, ad_o, ad_oe, hi_oe, m_ad, ad_w, hi_a;
   wire ready, rv, vv, as_n, ds_n, rnw, coe, m_en, m_wait, grant_n, sp;
   int err_count = 0, tests_run = 0, lat;
   xmb_row_t rows [0:9];
   // undriven low port toggles so a stale value never passes
   assign ad_w = (ad_oe == 8'hff) ? ad_o : m_en ? m_ad : 8'h5a ^ {8{clk}};
   always #2.5 clk = ~clk;
   xmb_bus_if xmb_bus_if_i (.I_CLOCK(clk), .I_RESET(rst), .I_REQ(req), .I_REQ_WRITE(wr), .I_REQ_ADDR(addr),
      .I_REQ_WDATA(wd), .I_REQ_KIND(kind), .I_REQ_MOVE_SPACE(ms), .I_SEL_DATA_SPACE_OP(sdo), .I_SEL_PROG_SPACE_OP(spo),
      .I_FLOAT_BUS(flt), .I_PROG_WAIT(pw), .I_DATA_WAIT(dw), .O_REQ_READY(ready), .O_RESP_VALID(rv),
      .O_RESP_RDATA(rdata), .O_VEC_VALID(vv), .O_START_ADDR(start), .O_ROM_ADDR(rom_a), .I_ROM_DATA(rom_a[7:0] ^ 8'h5a),
      .O_ADDR_LATCH_STROBE_N(as_n), .O_DATA_XFER_STROBE_N(ds_n), .O_READ_NOT_WRITE(rnw), .O_SPACE_PROG(sp),
      .O_CTRL_OE(coe), .I_MUXED_AD(ad_w), .O_MUXED_AD(ad_o), .O_MUXED_AD_OE(ad_oe), .O_HIGH_ADDR(hi_a),
      .O_HIGH_ADDR_OE(hi_oe), .I_EXT_WAIT(m_wait), .I_BUS_HOLD_REQUEST_N(hold_n), .O_BUS_HOLD_GRANT_N(grant_n));
   xmb_ext_mem xmb_ext_mem_i (.i_clk(clk), .i_as_n(as_n), .i_ds_n(ds_n), .i_rnw(rnw), .i_space(sp), .i_ad(ad_w),
      .i_slow(slow), .o_ad(m_ad), .o_ad_en(m_en), .o_wait(m_wait));
   task complete_run;
      if (err_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // data wait is the complement of the program wait so both fields vary
   task xfer(input xmb_row_t r);
      @(negedge clk);
      while (ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      {req, wr, kind, ms, addr, wd, pw, dw} <= {1'b1, r.w, r.k, r.ms, r.a, r.d, r.pw, r.pw ^ 3'h7};
      @(posedge clk);
      req <= 1'b0;
      lat = 0;
      do
      begin
         @(negedge clk);
         lat++;
      end while (rv !== 1'b1);
      rd = rdata;
   endtask
   task space_op(input bit to_data);
      @(posedge clk);
      {sdo, spo} <= {to_data, !to_data};
      @(posedge clk);
      {sdo, spo} <= 2'h0;
   endtask
   task reset_and_vector;
      @(posedge clk);
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      @(negedge clk);
      `XMB_CHK("reset pins", 13'h1c00, {as_n, ds_n, grant_n, coe, ad_oe, ready})
      @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      while (vv !== 1'b1) @(negedge clk);
      `XMB_CHK("start", 16'h5a5b, start)
   endtask
   initial
   begin
      rows[0] = '{0, 2'h0, 0, 16'h1fff, 8'h00, 8'ha5, 2, 3'h0};
      rows[1] = '{0, 2'h0, 0, 16'h2000, 8'h00, 8'h11, 5, 3'h0};
      rows[2] = '{1, 2'h0, 0, 16'h2001, 8'h3c, 8'h00, 5, 3'h0};
      rows[3] = '{0, 2'h0, 0, 16'h2001, 8'h00, 8'h3c, 8, 3'h3};
      rows[4] = '{1, 2'h1, 0, 16'h2002, 8'hc3, 8'h00, 5, 3'h7};
      rows[5] = '{0, 2'h0, 0, 16'h2002, 8'h00, 8'h13, 5, 3'h0};
      rows[6] = '{0, 2'h1, 0, 16'h2002, 8'h00, 8'hc3, 6, 3'h6};
      rows[7] = '{0, 2'h2, 0, 16'h2002, 8'h00, 8'hc3, 5, 3'h7};
      rows[8] = '{0, 2'h2, 1, 16'h2001, 8'h00, 8'h3c, 5, 3'h0};
      rows[9] = '{0, 2'h0, 0, 16'h0000, 8'h00, 8'h5a, 2, 3'h0};
      reset_and_vector;
      foreach (rows[i])
      begin
         xfer(rows[i]);
         `XMB_CHK("latency", rows[i].lat, lat)
         if (!rows[i].w) `XMB_CHK("rdata", rows[i].e, rd)
         if (rows[i].a > 16'h1fff) `XMB_CHK("high addr", rows[i].a[15:8], hi_a)
      end
      space_op(1'b1);
      xfer(rows[5]);
      `XMB_CHK("data space", 8'hc3, rd)
      space_op(1'b0);
      xfer(rows[5]);
      `XMB_CHK("prog space", 8'h13, rd)
      // pin wait reaches the engine two clocks late, so a row with programmed waits carries it
      slow <= 1'b1;
      xfer(rows[3]);
      slow <= 1'b0;
      `XMB_CHK("slow data", 8'h3c, rd)
      `XMB_CHK("slow longer", 1'b1, lat > rows[3].lat)
      @(posedge clk);
      flt <= 1'b1;
      repeat (4) @(negedge clk);
      `XMB_CHK("float", 18'h00000, {coe, ad_oe, hi_oe, ready})
      @(posedge clk);
      {flt, hold_n} <= 2'h0;
      for (int n = 0; n < 20 && grant_n !== 1'b0; n++) @(negedge clk);
      `XMB_CHK("hold", 2'h0, {grant_n, coe})
      @(posedge clk);
      hold_n <= 1'b1;
      xfer(rows[1]);
      `XMB_CHK("after hold", 8'h11, rd)
      reset_and_vector;
      complete_run;
   end
   initial
   begin
      repeat (4000) @(posedge clk);
      err_count++;
      complete_run;
   end
endmodule // xmb_bus_if_tb_top
